// [hdl/snsres_lta_bank.sv]
// writable long-term average store, one word per channel
`timescale 1ns/100ps
`default_nettype none
module snsres_lta_bank (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// engine update
	input  wire logic        eng_we_i,
	input  wire logic [1:0]  eng_ch_i,
	input  wire logic [15:0] eng_val_i,
	// host byte write
	input  wire logic        host_we_i,
	input  wire logic [2:0]  host_idx_i,
	input  wire logic [7:0]  host_data_i,
	// word view
	output logic [15:0] lta_o [snsres_pkg::NUM_LTA_CH]
);
	logic [15:0] lta_ff [snsres_pkg::NUM_LTA_CH]; // stored averages

	// per-channel storage; host byte write wins over engine update so
	// software can reseed a channel mid-measurement
	genvar g;
	generate
		for (g = 0; g < snsres_pkg::NUM_LTA_CH; g++) begin : g_ch
			wire host_hit = host_we_i && (host_idx_i[2:1] == 2'(g));
			wire eng_hit  = eng_we_i && (eng_ch_i == 2'(g));
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					lta_ff[g] <= snsres_pkg::WORD_RESET;
				end else if (host_hit) begin // RL14
					if (host_idx_i[0]) begin
						lta_ff[g][15:8] <= host_data_i;
					end else begin
						lta_ff[g][7:0] <= host_data_i;
					end
				end else if (eng_hit) begin
					lta_ff[g] <= eng_val_i;
				end
			end
			assign lta_o[g] = lta_ff[g];
		end
	endgenerate
endmodule
`default_nettype wire

// [hdl/snsres_pkg.sv]
// package for the sensor result register block: map, fields, carriers
// Operation
// (RL1) hysteresis flag bit7 gives delta sign
// (RL2) hysteresis bit6 set above touch threshold
// (RL3) hysteresis bit5 set above proximity threshold
// (RL4) hysteresis output sixteen bits, low byte first
// (RL5) magnetic bit2 set above touch threshold
// (RL6) magnetic bit1 set above proximity threshold
// (RL7) magnetic bit0 polarity: zero north, one south
// (RL8) flip-chip build inverts polarity bit meaning
// (RL9) magnetic output sixteen bits, up to 8000
// (RL10) temperature flag bit7 set on trip
// (RL11) temperature output sixteen bits, low first
// (RL12) calibrated variant adds offset of one hundred
// (RL13) channel counts read-only, low byte first
// (RL14) long-term averages readable and host writable
// (RL15) magnetic event raises global event bit2
// (RL16) temperature event raises global event bit4
// (RL17) unused flag bits zero, result writes ignored
// (RL18) low byte read latches paired high byte
package snsres_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_GLOBAL_EVENTS = 8'h11;
	localparam logic [7:0] ADDR_HYST_FLAGS    = 8'h13;
	localparam logic [7:0] ADDR_HYST_OUT_LO   = 8'h14;
	localparam logic [7:0] ADDR_HYST_OUT_HI   = 8'h15;
	localparam logic [7:0] ADDR_MAG_FLAGS     = 8'h16;
	localparam logic [7:0] ADDR_MAG_OUT_LO    = 8'h17;
	localparam logic [7:0] ADDR_MAG_OUT_HI    = 8'h18;
	localparam logic [7:0] ADDR_TEMP_FLAGS    = 8'h19;
	localparam logic [7:0] ADDR_TEMP_OUT_LO   = 8'h1a;
	localparam logic [7:0] ADDR_TEMP_OUT_HI   = 8'h1b;
	localparam logic [7:0] ADDR_COUNTS_FIRST  = 8'h20;
	localparam logic [7:0] ADDR_COUNTS_LAST   = 8'h2b;
	localparam logic [7:0] ADDR_LTA_FIRST     = 8'h30;
	localparam logic [7:0] ADDR_LTA_LAST      = 8'h35;

	// channel population
	localparam int NUM_COUNT_CH = 6;
	localparam int NUM_LTA_CH   = 3;

	// flag field positions
	localparam int HYST_SIGN_BIT  = 7;
	localparam int HYST_TOUCH_BIT = 6;
	localparam int HYST_PROX_BIT  = 5;
	localparam int MAG_TOUCH_BIT  = 2;
	localparam int MAG_PROX_BIT   = 1;
	localparam int MAG_POLAR_BIT  = 0;
	localparam int TEMP_TRIP_BIT  = 7;
	localparam int GEV_MAG_BIT    = 2;
	localparam int GEV_TEMP_BIT   = 4;

	// value limits and offsets
	localparam logic [15:0] MAG_OUT_MAX     = 16'h1f40;
	localparam logic [15:0] TEMP_CAL_OFFSET = 16'h0064;
	localparam logic [15:0] WORD_RESET      = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;

	// one measurement result from the sensing engines
	typedef struct packed {
		logic        hyst_counts_above; // counts exceed average
		logic        hyst_touch;        // delta above touch threshold
		logic        hyst_prox;         // delta above prox threshold
		logic [15:0] hyst_out;          // hysteresis detector value
		logic        mag_touch;         // magnetic delta above touch
		logic        mag_prox;          // magnetic delta above prox
		logic        mag_south;         // physical south field present
		logic [15:0] mag_out;           // magnetic detector value
		logic        temp_trip;         // temperature event
		logic [15:0] temp_raw;          // raw or die-celsius value
	} snsres_result_t;

	// host register access
	typedef struct packed {
		logic       rd; // read strobe, one cycle
		logic       wr; // write strobe, one cycle
		logic [7:0] addr;
		logic [7:0] wdata;
	} snsres_req_t;

endpackage

// [hdl/snsres_regs.sv]
// sensor result register file: flags, outputs, counts, averages
`timescale 1ns/100ps
`default_nettype none
module snsres_regs #(
	parameter bit FLIP_CHIP  = 1'b0, // wafer-level build inverts polarity
	parameter bit CALIBRATED = 1'b0  // die-celsius temperature variant
) (
	// clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        resetn_i,
	// sensing engine results
	input  wire logic                        meas_done_i,
	input  wire snsres_pkg::snsres_result_t  result_i,
	input  wire logic [15:0]                 counts_i [snsres_pkg::NUM_COUNT_CH],
	input  wire logic                        lta_we_i,
	input  wire logic [1:0]                  lta_ch_i,
	input  wire logic [15:0]                 lta_val_i,
	// host register access
	input  wire snsres_pkg::snsres_req_t     req_i,
	output logic [7:0]                       rdata_o,
	output logic                             rvalid_o,
	// global event bits and stored averages
	output logic                             mag_event_o,
	output logic                             temp_event_o,
	output logic [15:0]                      lta_o [snsres_pkg::NUM_LTA_CH]
);
	// reset release through two flops
	logic rst_s1_ff;
	logic rst_n_ff;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff  <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff  <= rst_s1_ff;
		end
	end

	// latched measurement results
	logic [7:0]  hyst_flags_ff;  // sign, touch, prox
	logic [15:0] hyst_out_ff;    // hysteresis output word
	logic [7:0]  mag_flags_ff;   // touch, prox, polarity
	logic [15:0] mag_out_ff;     // magnetic output word
	logic [7:0]  temp_flags_ff;  // trip flag
	logic [15:0] temp_out_ff;    // temperature word
	logic [15:0] counts_ff [snsres_pkg::NUM_COUNT_CH]; // channel counts
	logic        mag_event_ff;   // global event bit two
	logic        temp_event_ff;  // global event bit four
	logic [7:0]  shadow_hi_ff;   // high byte caught on low read
	logic [7:0]  rdata_ff;       // read data
	logic        rvalid_ff;      // read answer strobe

	// flag byte builders; unassigned positions stay zero
	logic [7:0] nxt_hyst_flags;
	logic [7:0] nxt_mag_flags;
	logic [7:0] nxt_temp_flags;
	logic [15:0] nxt_mag_out;
	logic [15:0] nxt_temp_out;
	always_comb begin
		nxt_hyst_flags = snsres_pkg::BYTE_ZERO; // RL17
		nxt_hyst_flags[snsres_pkg::HYST_SIGN_BIT] =
			result_i.hyst_counts_above; // RL1
		nxt_hyst_flags[snsres_pkg::HYST_TOUCH_BIT] =
			result_i.hyst_touch; // RL2
		nxt_hyst_flags[snsres_pkg::HYST_PROX_BIT] =
			result_i.hyst_prox; // RL3
		nxt_mag_flags = snsres_pkg::BYTE_ZERO; // RL17
		nxt_mag_flags[snsres_pkg::MAG_TOUCH_BIT] = result_i.mag_touch; // RL5
		nxt_mag_flags[snsres_pkg::MAG_PROX_BIT]  = result_i.mag_prox; // RL6
		// the flip-chip die is mounted upside down, so the sense reverses
		nxt_mag_flags[snsres_pkg::MAG_POLAR_BIT] =
			result_i.mag_south ^ FLIP_CHIP; // RL7 RL8
		nxt_temp_flags = snsres_pkg::BYTE_ZERO; // RL17
		nxt_temp_flags[snsres_pkg::TEMP_TRIP_BIT] = result_i.temp_trip; // RL10
		// clamp the field value to its documented span
		if (result_i.mag_out > snsres_pkg::MAG_OUT_MAX) begin // RL9
			nxt_mag_out = snsres_pkg::MAG_OUT_MAX;
		end else begin
			nxt_mag_out = result_i.mag_out;
		end
		// calibrated build reports celsius plus one hundred
		if (CALIBRATED) begin // RL12
			nxt_temp_out = 16'(result_i.temp_raw + snsres_pkg::TEMP_CAL_OFFSET);
		end else begin
			nxt_temp_out = result_i.temp_raw; // RL11
		end
	end

	// result capture once per measurement cycle
	always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			hyst_flags_ff <= snsres_pkg::BYTE_ZERO;
			hyst_out_ff   <= snsres_pkg::WORD_RESET;
			mag_flags_ff  <= snsres_pkg::BYTE_ZERO;
			mag_out_ff    <= snsres_pkg::WORD_RESET;
			temp_flags_ff <= snsres_pkg::BYTE_ZERO;
			temp_out_ff   <= snsres_pkg::WORD_RESET;
		end else if (meas_done_i) begin
			hyst_flags_ff <= nxt_hyst_flags;
			hyst_out_ff   <= result_i.hyst_out; // RL4
			mag_flags_ff  <= nxt_mag_flags;
			mag_out_ff    <= nxt_mag_out;
			temp_flags_ff <= nxt_temp_flags;
			temp_out_ff   <= nxt_temp_out;
		end
	end

	// channel counts, one word each
	genvar g;
	generate
		for (g = 0; g < snsres_pkg::NUM_COUNT_CH; g++) begin : g_cnt
			always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
				if (!rst_n_ff) begin
					counts_ff[g] <= snsres_pkg::WORD_RESET;
				end else if (meas_done_i) begin
					counts_ff[g] <= counts_i[g]; // RL13
				end
			end
		end
	endgenerate

	// address decode
	wire in_counts = (req_i.addr >= snsres_pkg::ADDR_COUNTS_FIRST) &&
		(req_i.addr <= snsres_pkg::ADDR_COUNTS_LAST);
	wire in_lta = (req_i.addr >= snsres_pkg::ADDR_LTA_FIRST) &&
		(req_i.addr <= snsres_pkg::ADDR_LTA_LAST);
	wire [7:0] cnt_off = req_i.addr - snsres_pkg::ADDR_COUNTS_FIRST;
	wire [7:0] lta_off = req_i.addr - snsres_pkg::ADDR_LTA_FIRST;
	wire [2:0] cnt_idx = cnt_off[3:1];
	wire [2:0] lta_idx = lta_off[3:1];
	// only the average bank accepts host writes
	wire lta_host_we = req_i.wr && in_lta; // RL14 RL17

	// the bank holding writable averages
	snsres_lta_bank u_lta (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_ff),
		.eng_we_i    (lta_we_i),
		.eng_ch_i    (lta_ch_i),
		.eng_val_i   (lta_val_i),
		.host_we_i   (lta_host_we),
		.host_idx_i  (lta_off[2:0]),
		.host_data_i (req_i.wdata),
		.lta_o       (lta_o)
	);

	// is this address the low byte of the hysteresis, magnetic or temperature output word
	function automatic logic is_low_byte(input logic [7:0] a);
		logic r;
		r = (a == snsres_pkg::ADDR_HYST_OUT_LO) ||
			(a == snsres_pkg::ADDR_MAG_OUT_LO) ||
			(a == snsres_pkg::ADDR_TEMP_OUT_LO);
		return r;
	endfunction

	// word seen at a low-byte output address or in the count and average ranges; zero elsewhere
	logic [15:0] word_sel;
	always_comb begin
		word_sel = snsres_pkg::WORD_RESET;
		if (in_counts) begin
			word_sel = counts_ff[cnt_idx];
		end else if (in_lta) begin
			word_sel = lta_o[lta_idx[1:0]];
		end else begin
			case (req_i.addr)
				snsres_pkg::ADDR_HYST_OUT_LO: word_sel = hyst_out_ff;
				snsres_pkg::ADDR_MAG_OUT_LO:  word_sel = mag_out_ff;
				snsres_pkg::ADDR_TEMP_OUT_LO: word_sel = temp_out_ff;
				default:                      word_sel = snsres_pkg::WORD_RESET;
			endcase
		end
	end

	wire pair_low = is_low_byte(req_i.addr) ||
		((in_counts || in_lta) && !req_i.addr[0]);
	wire pair_high = (req_i.addr == snsres_pkg::ADDR_HYST_OUT_HI) ||
		(req_i.addr == snsres_pkg::ADDR_MAG_OUT_HI) ||
		(req_i.addr == snsres_pkg::ADDR_TEMP_OUT_HI) ||
		((in_counts || in_lta) && req_i.addr[0]);

	// read data mux; high bytes come from the shadow so a word never
	// tears when the engine updates between the two byte reads
	logic [7:0] nxt_rdata;
	always_comb begin
		if (pair_low) begin
			nxt_rdata = word_sel[7:0];
		end else if (pair_high) begin
			nxt_rdata = shadow_hi_ff; // RL18
		end else begin
			case (req_i.addr)
				snsres_pkg::ADDR_GLOBAL_EVENTS: begin
					nxt_rdata = snsres_pkg::BYTE_ZERO;
					nxt_rdata[snsres_pkg::GEV_MAG_BIT]  = mag_event_ff;
					nxt_rdata[snsres_pkg::GEV_TEMP_BIT] = temp_event_ff;
				end
				snsres_pkg::ADDR_HYST_FLAGS: nxt_rdata = hyst_flags_ff;
				snsres_pkg::ADDR_MAG_FLAGS:  nxt_rdata = mag_flags_ff;
				snsres_pkg::ADDR_TEMP_FLAGS: nxt_rdata = temp_flags_ff;
				default:                     nxt_rdata = snsres_pkg::BYTE_ZERO;
			endcase
		end
	end

	// read answer and high-byte shadow
	always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rdata_ff     <= snsres_pkg::BYTE_ZERO;
			rvalid_ff    <= 1'b0;
			shadow_hi_ff <= snsres_pkg::BYTE_ZERO;
		end else begin
			rvalid_ff <= req_i.rd;
			if (req_i.rd) begin
				rdata_ff <= nxt_rdata;
			end
			if (req_i.rd && pair_low) begin
				shadow_hi_ff <= word_sel[15:8]; // RL18
			end
		end
	end

	// global event bits: level copies of the detector events
	always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			mag_event_ff  <= 1'b0;
			temp_event_ff <= 1'b0;
		end else if (meas_done_i) begin
			mag_event_ff  <= result_i.mag_touch | result_i.mag_prox; // RL15
			temp_event_ff <= result_i.temp_trip; // RL16
		end
	end

	assign rdata_o      = rdata_ff;
	assign rvalid_o     = rvalid_ff;
	assign mag_event_o  = mag_event_ff;
	assign temp_event_o = temp_event_ff;
endmodule
`default_nettype wire

// [sim/snsres_assertions.sv]
// concurrent checks on the result register block ports
`timescale 1ns/100ps
`default_nettype none
module snsres_assertions (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// engine side
	input wire logic meas_done_i,
	input wire snsres_pkg::snsres_result_t result_i,
	input wire logic lta_we_i,
	// host side
	input wire snsres_pkg::snsres_req_t req_i,
	input wire logic [7:0] rdata_o,
	input wire logic rvalid_o,
	// events and averages
	input wire logic mag_event_o,
	input wire logic temp_event_o,
	input wire logic [15:0] lta_o [snsres_pkg::NUM_LTA_CH]
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// host write aimed at an average byte
	wire hit = req_i.wr && req_i.addr inside {[8'h30:8'h35]};
	logic hit_ff; // write landed last cycle
	logic [7:0] wa_ff; // its address
	logic [7:0] wd_ff; // its data
	// remember the write so the next cycle can judge it
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hit_ff <= 1'b0;
			wa_ff <= 8'h00;
			wd_ff <= 8'h00;
		end else begin
			hit_ff <= hit;
			wa_ff <= req_i.addr;
			wd_ff <= req_i.wdata;
		end
	end
	wire [15:0] lw = lta_o[wa_ff[2:1]]; // word just written
	sequence rd_s(a);
		req_i.rd && req_i.addr == a;
	endsequence
	rd_answer_a: assert property (req_i.rd |=> rvalid_o)
		else $error("read not answered");
	no_spur_a: assert property (!req_i.rd |=> !rvalid_o)
		else $error("valid without read");
	rdata_hold_a: assert property (!req_i.rd |=> $stable(rdata_o))
		else $error("read data moved");
	unmapped_zero_a: assert property (rd_s(8'h00) |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	hyst_pad_a: assert property (rd_s(8'h13) |=> rdata_o[4:0] == 5'h00)
		else $error("hysteresis spare bits set");
	mag_pad_a: assert property (rd_s(8'h16) |=> rdata_o[7:3] == 5'h00)
		else $error("magnetic spare bits set");
	temp_pad_a: assert property (rd_s(8'h19) |=> rdata_o[6:0] == 7'h00)
		else $error("temperature spare bits set");
	mag_clamp_a: assert property (rd_s(8'h18) |=> rdata_o <= 8'h1f)
		else $error("magnetic output above limit");
	mag_event_a: assert property (meas_done_i |=> mag_event_o ==
		($past(result_i.mag_touch) | $past(result_i.mag_prox)))
		else $error("magnetic event wrong");
	temp_event_a: assert property (meas_done_i |=>
		temp_event_o == $past(result_i.temp_trip))
		else $error("temperature event wrong");
	lta_write_a: assert property (hit_ff |->
		(wa_ff[0] ? lw[15:8] : lw[7:0]) == wd_ff)
		else $error("average write lost");
	ro_write_a: assert property (req_i.wr && !hit && !lta_we_i |=>
		$stable({lta_o[0], lta_o[1], lta_o[2]}))
		else $error("stray write changed averages");
endmodule
bind snsres_regs snsres_assertions u_chk (.core_clk_i(core_clk_i),
	.resetn_i(resetn_i), .meas_done_i(meas_done_i), .result_i(result_i),
	.lta_we_i(lta_we_i), .req_i(req_i), .rdata_o(rdata_o),
	.rvalid_o(rvalid_o), .mag_event_o(mag_event_o),
	.temp_event_o(temp_event_o), .lta_o(lta_o));
`default_nettype wire

// [sim/snsres_host.sv]
// host controller model issuing register reads and writes
`timescale 1ns/100ps
`default_nettype none
module snsres_host (
	// clock
	input wire logic core_clk_i,
	// register access
	output var snsres_pkg::snsres_req_t req_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	int n_lost; // reads that were never answered
	initial begin
		req_o = '0;
		n_lost = 0;
	end
	// one byte write; idle lines show inverted values, not stale ones
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk_i);
		req_o = '{1'b0, 1'b1, a, v};
		@(negedge core_clk_i);
		req_o = '{1'b0, 1'b0, ~a, ~v};
	endtask
	// one byte read, answer awaited under a bound
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		int i;
		@(negedge core_clk_i);
		req_o = '{1'b1, 1'b0, a, 8'h00};
		@(negedge core_clk_i);
		req_o = '{1'b0, 1'b0, ~a, 8'hff};
		for (i = 0; i < 4 && rvalid_i !== 1'b1; i++) @(negedge core_clk_i);
		if (i == 4) n_lost++;
		v = rdata_i;
	endtask
endmodule
`default_nettype wire

// [sim/snsres_regs_tb.sv]
// self-checking bench for the result register block
`timescale 1ns/100ps
`default_nettype none
module snsres_regs_tb;
	typedef struct {logic [7:0] a; logic [7:0] e;} snsres_row_t;
	logic clk, rst_n, done, lwe, rvalid, mev, tev;
	logic [1:0] lch;
	logic [15:0] lval;
	logic [7:0] rdata, d;
	logic [7:0] rdata2; // read byte of the flip-chip calibrated build
	snsres_pkg::snsres_result_t res;
	snsres_pkg::snsres_req_t req;
	logic [15:0] cnt [snsres_pkg::NUM_COUNT_CH];
	logic [15:0] lta [snsres_pkg::NUM_LTA_CH];
	int n_fail, n_compared;
	// reads after the first measurement, address beside expected byte
	snsres_row_t rows [16] = '{'{8'h13, 8'ha0}, '{8'h14, 8'h34},
		'{8'h15, 8'h12}, '{8'h16, 8'h05}, '{8'h17, 8'h40}, '{8'h18, 8'h1f},
		'{8'h19, 8'h80}, '{8'h1a, 8'h55}, '{8'h1b, 8'h00}, '{8'h20, 8'h10},
		'{8'h21, 8'hc0}, '{8'h2a, 8'h15}, '{8'h2b, 8'hc0}, '{8'h11, 8'h14},
		'{8'h00, 8'h00}, '{8'h36, 8'h00}};
	snsres_regs dut (.core_clk_i(clk), .resetn_i(rst_n), .meas_done_i(done),
		.result_i(res), .counts_i(cnt), .lta_we_i(lwe), .lta_ch_i(lch),
		.lta_val_i(lval), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
		.mag_event_o(mev), .temp_event_o(tev), .lta_o(lta));
	// second build shares the host bus; only its read byte is watched
	snsres_regs #(.FLIP_CHIP(1'b1), .CALIBRATED(1'b1)) dut2 (
		.core_clk_i(clk), .resetn_i(rst_n), .meas_done_i(done),
		.result_i(res), .counts_i(cnt), .lta_we_i(lwe), .lta_ch_i(lch),
		.lta_val_i(lval), .req_i(req), .rdata_o(rdata2), .rvalid_o(),
		.mag_event_o(), .temp_event_o(), .lta_o());
	snsres_host u_host (.core_clk_i(clk), .req_o(req), .rdata_i(rdata),
		.rvalid_i(rvalid));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, d);
		check(d, e);
	endtask
	// one measurement pulse with counts base+channel
	task automatic meas(input snsres_pkg::snsres_result_t r,
		input logic [15:0] b);
		@(negedge clk);
		res = r;
		foreach (cnt[i]) cnt[i] = b + 16'(i);
		done = 1'b1;
		@(negedge clk);
		done = 1'b0;
	endtask
	task automatic complete_run;
		n_fail += u_host.n_lost;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		n_fail = 0;
		n_compared = 0;
		rst_n = 1'b0;
		done = 1'b0;
		lwe = 1'b0;
		lch = 2'd0;
		lval = 16'h0000;
		res = '0;
		foreach (cnt[i]) cnt[i] = 16'h0000;
		repeat (20) @(negedge clk);
		check({rvalid, mev, tev, lta[0][4:0]}, 8'h00);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		$display("reset done");
		meas('{1'b1, 1'b0, 1'b1, 16'h1234, 1'b1, 1'b0, 1'b1, 16'h1f40,
			1'b1, 16'h0055}, 16'hc010);
		foreach (rows[i]) rc(rows[i].a, rows[i].e);
		$display("table done");
		// high byte must come from the capture made at the low read
		rc(8'h14, 8'h34);
		meas('{1'b0, 1'b1, 1'b0, 16'hbeef, 1'b0, 1'b1, 1'b0, 16'h2000,
			1'b0, 16'h0007}, 16'h0000);
		rc(8'h15, 8'h12);
		rc(8'h13, 8'h40);
		rc(8'h16, 8'h02);
		check(rdata2, 8'h03);
		rc(8'h17, 8'h40);
		rc(8'h18, 8'h1f);
		rc(8'h11, 8'h04);
		rc(8'h19, 8'h00);
		rc(8'h1a, 8'h07);
		check(rdata2, 8'h6b);
		u_host.wr(8'h14, 8'hff);
		rc(8'h14, 8'hef);
		rc(8'h15, 8'hbe);
		$display("coherence done");
		u_host.wr(8'h30, 8'h11);
		u_host.wr(8'h31, 8'h22);
		u_host.wr(8'h35, 8'ha5);
		check(lta[0][15:8], 8'h22);
		rc(8'h30, 8'h11);
		rc(8'h31, 8'h22);
		rc(8'h34, 8'h00);
		rc(8'h35, 8'ha5);
		@(negedge clk);
		lwe = 1'b1;
		lch = 2'd1;
		lval = 16'h7e81;
		@(negedge clk);
		lwe = 1'b0;
		rc(8'h32, 8'h81);
		rc(8'h33, 8'h7e);
		$display("averages done");
		// second reset mid-run: results, events and averages must clear
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		check({rvalid, mev, tev, lta[1][4:0]}, 8'h00);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		rc(8'h13, 8'h00);
		rc(8'h32, 8'h00);
		rc(8'h11, 8'h00);
		$display("second reset done");
		complete_run();
	end
endmodule
`default_nettype wire
